/* File: rtl/smc_pkg.sv */
package smc_pkg;

  // ----------------------------------------------------------------
  // Register map (word indices on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] SMC_A_STALL_MIN  = 4'h0;
  localparam logic [3:0] SMC_A_JERK       = 4'h1;
  localparam logic [3:0] SMC_A_GEN_CFG    = 4'h2;
  localparam logic [3:0] SMC_A_LIMIT_CFG  = 4'h3;
  localparam logic [3:0] SMC_A_CTRL       = 4'h4;
  localparam logic [3:0] SMC_A_DECAY_CFG  = 4'h5;
  localparam logic [3:0] SMC_A_STATUS     = 4'h6;
  localparam logic [3:0] SMC_A_ERR_CODE   = 4'h7;
  localparam logic [3:0] SMC_A_ACK        = 4'h8;
  localparam logic [3:0] SMC_A_CYCLE_TKS  = 4'h9;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [15:0] SMC_STALL_MIN_RST = 16'h0000;
  localparam logic [7:0]  SMC_CFG8_RST      = 8'h00;
  localparam logic [15:0] SMC_CTRL_RST      = 16'h0000;
  localparam int          SMC_CTRL_STALL_EN = 15;
  localparam logic [6:0]  SMC_JERK_MAX      = 7'h50;
  localparam int          SMC_FIFO_DEPTH    = 80;
  localparam logic [3:0]  SMC_DECAY_ALWAYS  = 4'hF;
  localparam logic [7:0]  SMC_GEN_MASK      = 8'h07;
  localparam logic [7:0]  SMC_LIM_MASK      = 8'h8F;
  localparam int          SMC_LIM_DIRMON    = 7;
  localparam logic [1:0]  SMC_POL_OFF       = 2'h0;
  localparam logic [1:0]  SMC_POL_LOW       = 2'h1;
  localparam logic [1:0]  SMC_POL_HIGH      = 2'h3;
  localparam logic [1:0]  SMC_CYC_25        = 2'h0;
  localparam logic [1:0]  SMC_CYC_10        = 2'h1;
  localparam logic [1:0]  SMC_CYC_5         = 2'h2;

  // Error codes for limit events (arbitrary values)
  localparam logic [7:0] SMC_ERR_NONE = 8'h00;
  localparam logic [7:0] SMC_ERR_NEG  = 8'h01;
  localparam logic [7:0] SMC_ERR_POS  = 8'h02;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SMC_CLK_MHZ   = 100;
  localparam int SMC_CYC25_MS  = 25;
  localparam int SMC_CYC10_MS  = 10;
  localparam int SMC_CYC5_MS   = 5;
  localparam int SMC_TICKS_25  = SMC_CYC25_MS * 1000 * SMC_CLK_MHZ;
  localparam int SMC_TICKS_10  = SMC_CYC10_MS * 1000 * SMC_CLK_MHZ;
  localparam int SMC_TICKS_5   = SMC_CYC5_MS * 1000 * SMC_CLK_MHZ;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic       wr;
    logic       rd;
    logic [31:0] wdata;
  } smc_bus_t;

  typedef struct packed {
    logic        running;
    logic        target_reached;
    logic        pos_mode;
    logic signed [15:0] speed;
  } smc_axis_t;

endpackage : smc_pkg

/* File: rtl/smc_jerk_avg.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Moving average of the per-cycle speed setpoint
// ----------------------------------------------------------------
module smc_jerk_avg
  import smc_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire logic               tick,
  input  wire logic [6:0]         depth,
  input  wire logic signed [15:0] sp_in,
  output logic signed [15:0]      sp_out
);
  import smc_pkg::*;

  logic signed [15:0] hist_q [SMC_FIFO_DEPTH];
  logic signed [23:0] sum_q;
  logic signed [15:0] oldest;

  assign oldest = (depth == 7'h00) ? 16'sh0000 : hist_q[depth - 7'h01];

  // Shift register of past setpoints
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SMC_FIFO_DEPTH; i++) hist_q[i] <= 16'sh0000;
    end else if (tick) begin
      hist_q[0] <= sp_in;
      for (int i = 1; i < SMC_FIFO_DEPTH; i++) hist_q[i] <= hist_q[i-1];
    end
  end

  // Running sum over the active depth; a depth change only occurs while stopped or on target
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sum_q <= 24'sh000000;
    end else if (tick) begin
      sum_q <= sum_q + 24'(sp_in) - 24'(oldest);
    end
  end

  // Output: bypass at zero depth
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sp_out <= 16'sh0000;
    end else if (depth == 7'h00) begin
      sp_out <= sp_in;
    end else begin
      sp_out <= 16'(sum_q / $signed({17'h0, depth}));
    end
  end
endmodule // smc_jerk_avg
`default_nettype wire

/* File: rtl/smc_limit_sw.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// One limit switch: sync, polarity, active-edge detect
// ----------------------------------------------------------------
module smc_limit_sw
  import smc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       pin,
  input  wire logic [1:0] pol,
  output logic            active,
  output logic            rise
);
  import smc_pkg::*;

  logic s1_q;
  logic s2_q;
  logic act_q;
  logic act_d;

  // Two-stage synchroniser
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
    end
  end

  // Polarity decode; reserved 10 treated as off
  always_comb begin
    act_d = 1'b0;
    case (pol)
      SMC_POL_LOW:  act_d = ~s2_q;
      SMC_POL_HIGH: act_d = s2_q;
      default:      act_d = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) act_q <= 1'b0;
    else         act_q <= act_d;
  end

  assign active = act_q;
  assign rise   = act_d & ~act_q;
endmodule // smc_limit_sw
`default_nettype wire

/* File: rtl/smc_motion_cfg.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Stepper axis configuration, jerk limit and limit switches
// ----------------------------------------------------------------
module smc_motion_cfg
  import smc_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire smc_pkg::smc_bus_t  bus,
  output logic [31:0]             rdata,
  input  wire smc_pkg::smc_axis_t axis,
  input  wire logic               stall_raw,
  input  wire logic               lim_neg_pin,
  input  wire logic               lim_pos_pin,
  output logic                    cycle_tick,
  output logic signed [15:0]      speed_cmd,
  output logic [3:0]              decay_thr,
  output logic                    decay_always,
  output logic                    stall_det_en,
  output logic                    stall_err,
  output logic                    limit_warn,
  output logic                    ramp_to_zero,
  output logic                    ext_ctrl_mode,
  output logic [1:0]              cycle_sel
);
  import smc_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] stall_min_q;
  logic [6:0]  jerk_req_q;
  logic [6:0]  jerk_act_q;
  logic [7:0]  gen_cfg_q;
  logic [7:0]  lim_cfg_q;
  logic [15:0] ctrl_q;
  logic [7:0]  decay_cfg_q;
  logic [7:0]  err_code_q;
  logic        warn_q;
  logic        stall_err_q;
  logic [31:0] tick_cnt_q;
  logic [31:0] tick_max;
  logic [15:0] speed_abs;
  logic        above_min;
  logic        neg_act;
  logic        pos_act;
  logic        neg_rise;
  logic        pos_rise;
  logic        mov_neg;
  logic        mov_pos;
  logic        neg_trip;
  logic        pos_trip;
  logic        refuse;
  logic        ack_wr;
  logic signed [15:0] sp_gated;

  assign ack_wr = bus.wr && (bus.addr == SMC_A_ACK);

  // Register writes; jerk value clamped on entry
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stall_min_q <= SMC_STALL_MIN_RST;
      jerk_req_q  <= 7'h00;
      gen_cfg_q   <= SMC_CFG8_RST;
      lim_cfg_q   <= SMC_CFG8_RST;
      ctrl_q      <= SMC_CTRL_RST;
      decay_cfg_q <= SMC_CFG8_RST;
    end else if (bus.wr) begin
      if (bus.addr == SMC_A_STALL_MIN) begin
        stall_min_q <= bus.wdata[15:0];
      end else if (bus.addr == SMC_A_JERK) begin
        jerk_req_q <= (bus.wdata[7:0] > {1'b0, SMC_JERK_MAX}) ?
                      SMC_JERK_MAX : bus.wdata[6:0];
      end else if (bus.addr == SMC_A_GEN_CFG) begin
        gen_cfg_q <= bus.wdata[7:0] & SMC_GEN_MASK;
      end else if (bus.addr == SMC_A_LIMIT_CFG) begin
        lim_cfg_q <= bus.wdata[7:0] & SMC_LIM_MASK;
      end else if (bus.addr == SMC_A_CTRL) begin
        ctrl_q <= bus.wdata[15:0];
      end else if (bus.addr == SMC_A_DECAY_CFG) begin
        decay_cfg_q <= bus.wdata[7:0];
      end
    end
  end

  // Jerk depth adopted only while stopped or on target
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      jerk_act_q <= 7'h00;
    end else if (!axis.running || (axis.pos_mode && axis.target_reached)) begin
      jerk_act_q <= jerk_req_q;
    end
  end

  // ----------------------------------------------------------------
  // Motion generator cycle
  // ----------------------------------------------------------------
  assign ext_ctrl_mode = gen_cfg_q[0];
  assign cycle_sel     = gen_cfg_q[2:1];

  // Reserved 11 keeps the default 25 ms rather than stopping the profile
  always_comb begin
    case (gen_cfg_q[2:1])
      SMC_CYC_10: tick_max = 32'(SMC_TICKS_10 - 1);
      SMC_CYC_5:  tick_max = 32'(SMC_TICKS_5 - 1);
      default:    tick_max = 32'(SMC_TICKS_25 - 1);
    endcase
  end

  // Tick counter; speed units scale with this cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 32'h0000_0000;
      cycle_tick <= 1'b0;
    end else if (tick_cnt_q >= tick_max) begin
      tick_cnt_q <= 32'h0000_0000;
      cycle_tick <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      cycle_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Stall gate and mixed decay
  // ----------------------------------------------------------------
  assign speed_abs = axis.speed[15] ? 16'(-axis.speed) : axis.speed;
  assign above_min = speed_abs > stall_min_q;

  assign stall_det_en = above_min && ctrl_q[SMC_CTRL_STALL_EN];

  // Low speed forces threshold 15
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      decay_thr    <= SMC_DECAY_ALWAYS;
      decay_always <= 1'b1;
    end else begin
      decay_thr    <= above_min ? decay_cfg_q[3:0] : SMC_DECAY_ALWAYS;
      decay_always <= !above_min || (decay_cfg_q[3:0] == SMC_DECAY_ALWAYS);
    end
  end

  // Sticky stall error, reported only when gated
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stall_err_q <= 1'b0;
    end else if (stall_raw && stall_det_en) begin
      stall_err_q <= 1'b1;
    end else if (ack_wr) begin
      stall_err_q <= 1'b0;
    end
  end
  assign stall_err = stall_err_q;

  // ----------------------------------------------------------------
  // Limit switches
  // ----------------------------------------------------------------
  smc_limit_sw u_neg (
    .clock  (clock),
    .resetn (resetn),
    .pin    (lim_neg_pin),
    .pol    (lim_cfg_q[1:0]),
    .active (neg_act),
    .rise   (neg_rise)
  );

  smc_limit_sw u_pos (
    .clock  (clock),
    .resetn (resetn),
    .pin    (lim_pos_pin),
    .pol    (lim_cfg_q[3:2]),
    .active (pos_act),
    .rise   (pos_rise)
  );

  assign mov_neg = axis.speed < 16'sh0000;
  assign mov_pos = axis.speed > 16'sh0000;

  // Trip on active edge; direction qualified only when monitoring
  assign neg_trip = neg_rise && (!lim_cfg_q[SMC_LIM_DIRMON] || mov_neg);
  assign pos_trip = pos_rise && (!lim_cfg_q[SMC_LIM_DIRMON] || mov_pos);

  // Warning and cause; event wins over acknowledge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      warn_q     <= 1'b0;
      err_code_q <= SMC_ERR_NONE;
    end else if (neg_trip || pos_trip) begin
      warn_q     <= 1'b1;
      err_code_q <= neg_trip ? SMC_ERR_NEG : SMC_ERR_POS;
    end else if (ack_wr) begin
      warn_q     <= 1'b0;
      err_code_q <= SMC_ERR_NONE;
    end
  end

  assign limit_warn   = warn_q;
  assign ramp_to_zero = warn_q;   // Ramp only; device state and current untouched

  // Refuse moves toward an active switch under monitoring
  assign refuse = lim_cfg_q[SMC_LIM_DIRMON] &&
                  ((neg_act && mov_neg) || (pos_act && mov_pos));
  assign sp_gated = (warn_q || refuse) ? 16'sh0000 : axis.speed;

  smc_jerk_avg u_avg (
    .clock  (clock),
    .resetn (resetn),
    .tick   (cycle_tick),
    .depth  (jerk_act_q),
    .sp_in  (sp_gated),
    .sp_out (speed_cmd)
  );

  // ----------------------------------------------------------------
  // Read port, one cycle latency; unmapped reads zero
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      if (bus.addr == SMC_A_STALL_MIN) begin
        rdata <= {16'h0000, stall_min_q};
      end else if (bus.addr == SMC_A_JERK) begin
        rdata <= {25'h0000000, jerk_req_q};
      end else if (bus.addr == SMC_A_GEN_CFG) begin
        rdata <= {24'h000000, gen_cfg_q};
      end else if (bus.addr == SMC_A_LIMIT_CFG) begin
        rdata <= {24'h000000, lim_cfg_q};
      end else if (bus.addr == SMC_A_CTRL) begin
        rdata <= {16'h0000, ctrl_q};
      end else if (bus.addr == SMC_A_DECAY_CFG) begin
        rdata <= {24'h000000, decay_cfg_q};
      end else if (bus.addr == SMC_A_STATUS) begin
        rdata <= {19'h00000, jerk_act_q, refuse, stall_det_en,
                  stall_err_q, pos_act, neg_act, warn_q};
      end else if (bus.addr == SMC_A_ERR_CODE) begin
        rdata <= {24'h000000, err_code_q};
      end else if (bus.addr == SMC_A_CYCLE_TKS) begin
        rdata <= tick_max;
      end else begin
        rdata <= 32'h0000_0000;
      end
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule // smc_motion_cfg
`default_nettype wire

/* File: dv/smc_motion_cfg_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the axis configuration block
// ----------------------------------------------------------------
module smc_motion_cfg_properties
  import smc_pkg::*;
(
  input wire logic               clock,
  input wire logic               resetn,
  input wire smc_pkg::smc_bus_t  bus,
  input wire logic [31:0]        rdata,
  input wire smc_pkg::smc_axis_t axis,
  input wire logic               stall_raw,
  input wire logic               lim_neg_pin,
  input wire logic               lim_pos_pin,
  input wire logic               cycle_tick,
  input wire logic signed [15:0] speed_cmd,
  input wire logic [3:0]         decay_thr,
  input wire logic               decay_always,
  input wire logic               stall_det_en,
  input wire logic               stall_err,
  input wire logic               limit_warn,
  input wire logic               ramp_to_zero,
  input wire logic               ext_ctrl_mode,
  input wire logic [1:0]         cycle_sel
);
  logic [15:0] min_q;
  logic        sen_q;
  logic [3:0]  dec_q;
  logic [7:0]  gen_q;
  logic [2:0]  age_q;
  logic [1:0]  pin_q;
  logic [16:0] mag;
  logic        fast;
  logic        ack;

  // Magnitude in 17 bits so the most negative speed cannot wrap
  assign mag  = axis.speed[15] ? ~{1'b1, axis.speed} + 17'h1 : {1'b0, axis.speed};
  assign fast = mag > {1'b0, min_q};
  assign ack  = bus.wr && bus.addr == SMC_A_ACK;

  // Shadow copies of the settings the outputs depend on
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      min_q <= SMC_STALL_MIN_RST;
      sen_q <= 1'b0;
      dec_q <= 4'h0;
      gen_q <= SMC_CFG8_RST;
    end else if (bus.wr) begin
      if (bus.addr == SMC_A_STALL_MIN) min_q <= bus.wdata[15:0];
      if (bus.addr == SMC_A_CTRL) sen_q <= bus.wdata[SMC_CTRL_STALL_EN];
      if (bus.addr == SMC_A_DECAY_CFG) dec_q <= bus.wdata[3:0];
      if (bus.addr == SMC_A_GEN_CFG) gen_q <= bus.wdata[7:0] & SMC_GEN_MASK;
    end
  end

  // Cycles since either switch pin last moved, saturating at 7
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 2'h0;
      age_q <= 3'h7;
    end else begin
      pin_q <= {lim_pos_pin, lim_neg_pin};
      age_q <= (pin_q != {lim_pos_pin, lim_neg_pin}) ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_STALL_EN:
  assert property (stall_det_en == (fast && sen_q)) else $error("stall enable wrong");
  AST_DECAY_LOW:
  assert property ((!fast) [*2] |-> decay_thr == SMC_DECAY_ALWAYS) else $error("slow decay");
  AST_DECAY_USER:
  assert property (fast [*2] ##0 $stable(dec_q) |-> decay_thr == dec_q)
    else $error("user decay not applied");
  AST_DECAY_ALWAYS:
  assert property (decay_always == (decay_thr == SMC_DECAY_ALWAYS)) else $error("decay always");
  AST_STALL_QUIET:
  assert property (!fast && !stall_err |=> !stall_err) else $error("stall at low speed");
  AST_RDATA_IDLE:
  assert property (!$past(bus.rd) |-> rdata == 32'h0) else $error("read data outside slot");
  AST_GEN_CFG:
  assert property ({ext_ctrl_mode, cycle_sel} == {gen_q[0], gen_q[2:1]}) else $error("gen cfg");
  AST_WARN_HOLD:
  assert property (limit_warn && !ack |=> limit_warn) else $error("warning dropped");
  AST_ACK_CLEAR:
  assert property (ack && age_q == 3'h7 |=> !limit_warn) else $error("ack ignored");
  AST_WARN_CAUSE:
  assert property ($rose(limit_warn) |-> age_q inside {[3'h2:3'h3]}) else $error("no pin edge");
  AST_RAMP:
  assert property (ramp_to_zero == limit_warn) else $error("ramp not tied to warning");
endmodule // smc_motion_cfg_properties

bind smc_motion_cfg smc_motion_cfg_properties i_props (
  .clock(clock), .resetn(resetn), .bus(bus), .rdata(rdata), .axis(axis),
  .stall_raw(stall_raw), .lim_neg_pin(lim_neg_pin), .lim_pos_pin(lim_pos_pin),
  .cycle_tick(cycle_tick), .speed_cmd(speed_cmd), .decay_thr(decay_thr),
  .decay_always(decay_always), .stall_det_en(stall_det_en), .stall_err(stall_err),
  .limit_warn(limit_warn), .ramp_to_zero(ramp_to_zero), .ext_ctrl_mode(ext_ctrl_mode),
  .cycle_sel(cycle_sel));
`default_nettype wire

/* File: dv/smc_axis_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Axis and limit switch stand-in
// ----------------------------------------------------------------
module smc_axis_model
  import smc_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire logic signed [15:0] speed_req,
  input  wire logic [1:0]         hit,
  input  wire logic [1:0]         high,
  output var smc_pkg::smc_axis_t  axis,
  output logic                    lim_neg_pin,
  output logic                    lim_pos_pin
);
  import smc_pkg::*;

  // Axis state; a zero setpoint counts as stopped
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      axis <= '0;
    end else begin
      axis <= '{speed_req != 16'sh0, 1'b0, 1'b1, speed_req};
    end
  end

  // Contacts: wiring sense picks the level, released contact reads inverse
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lim_neg_pin <= 1'b1;
      lim_pos_pin <= 1'b1;
    end else begin
      lim_neg_pin <= hit[0] ~^ high[0];
      lim_pos_pin <= hit[1] ~^ high[1];
    end
  end
endmodule // smc_axis_model
`default_nettype wire

/* File: dv/smc_motion_cfg_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module smc_motion_cfg_bench;
  import smc_pkg::*;
  logic               clock, resetn, stall_raw, cycle_tick, decay_always, stall_det_en;
  logic               stall_err, limit_warn, ramp_to_zero, ext_ctrl_mode, lim_neg_pin, lim_pos_pin;
  logic [1:0]         cycle_sel, hit, high;
  logic [3:0]         decay_thr;
  logic [31:0]        rdata, d, v;
  logic signed [15:0] speed_cmd, speed_req;
  smc_bus_t           bus;
  smc_axis_t          axis;
  int                 fails, checked;
  logic signed [15:0] sp [8] = '{16'sh0, 16'sd100, -16'sd100, 16'sd101, -16'sd101, 16'sh7FFF,
                                 16'sh8000, 16'sd37};
  logic [7:0]         jv [6] = '{8'h00, 8'h01, 8'h50, 8'h51, 8'hFF, 8'h4F};

  smc_motion_cfg i_dut (.clock(clock), .resetn(resetn), .bus(bus), .rdata(rdata), .axis(axis),
    .stall_raw(stall_raw), .lim_neg_pin(lim_neg_pin), .lim_pos_pin(lim_pos_pin),
    .cycle_tick(cycle_tick), .speed_cmd(speed_cmd), .decay_thr(decay_thr),
    .decay_always(decay_always), .stall_det_en(stall_det_en), .stall_err(stall_err),
    .limit_warn(limit_warn), .ramp_to_zero(ramp_to_zero), .ext_ctrl_mode(ext_ctrl_mode),
    .cycle_sel(cycle_sel));
  smc_axis_model i_axis (.clock(clock), .resetn(resetn), .speed_req(speed_req), .hit(hit),
    .high(high), .axis(axis), .lim_neg_pin(lim_neg_pin), .lim_pos_pin(lim_pos_pin));

  // ----------------------------------------------------------------
  // Bus cycles, expectations and comparisons
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] x);
    @(posedge clock);
    bus <= '{a, 1'b1, 1'b0, x};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] x);
    @(posedge clock);
    bus <= '{a, 1'b0, 1'b1, 32'h0};
    @(posedge clock);
    bus.rd <= 1'b0;
    // Read data stand in the cycle after the strobe; take them at its closing edge
    @(posedge clock);
    x = rdata;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpb(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    rd(a, d);
    cmp(d, exp);
  endtask
  function automatic logic [31:0] jexp(input logic [7:0] x);
    return (x > 8'd80) ? 32'd80 : {24'h0, x};
  endfunction
  // Reserved cycle code falls back to the 25 ms period
  function automatic logic [31:0] cyc(input logic [1:0] c);
    return (c == SMC_CYC_10) ? SMC_TICKS_10 - 1 :
           (c == SMC_CYC_5) ? SMC_TICKS_5 - 1 : SMC_TICKS_25 - 1;
  endfunction
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Whole run needs under a thousand cycles; this cuts a hang
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    stop_test;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    bus = '0; resetn = 1'b0; stall_raw = 1'b0; speed_req = 16'sh0; hit = 2'h0; high = 2'h0;
    fails = 0;
    checked = 0;
    v = $urandom(32'h96c92571);
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (int a = 0; a < 4; a++) rchk(a[3:0], 32'h0);
    rchk(4'hF, 32'h0);
    $display("test reset values done");
    // Random settings; limit polarity kept at off or active-low so idle pins stay quiet
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      v[2:1] = i[1:0];
      wr(SMC_A_STALL_MIN, v);
      rchk(SMC_A_STALL_MIN, {16'h0, v[15:0]});
      wr(SMC_A_GEN_CFG, v);
      rchk(SMC_A_GEN_CFG, v & {24'h0, SMC_GEN_MASK});
      cmp({29'h0, ext_ctrl_mode, cycle_sel}, {29'h0, v[0], v[2:1]});
      rchk(SMC_A_CYCLE_TKS, cyc(v[2:1]));
      wr(SMC_A_LIMIT_CFG, v & 32'hF5);
      rchk(SMC_A_LIMIT_CFG, v & 32'h85);
    end
    foreach (jv[i]) begin
      wr(SMC_A_JERK, {24'($urandom), jv[i]});
      rchk(SMC_A_JERK, jexp(jv[i]));
    end
    wr(SMC_A_LIMIT_CFG, 32'h0);
    $display("test register access done");
    // Speed gate around a minimum of 100, stall source always asserting
    wr(SMC_A_CTRL, 32'h8000);
    wr(SMC_A_DECAY_CFG, 32'h5);
    wr(SMC_A_STALL_MIN, 32'd100);
    // Zero depth at standstill so the setpoint passes straight through
    wr(SMC_A_JERK, 32'h0);
    stall_raw <= 1'b1;
    foreach (sp[i]) begin
      speed_req <= sp[i];
      wr(SMC_A_ACK, 32'h0);
      repeat (4) @(posedge clock);
      cmpb(stall_det_en, sp[i] > 100 || sp[i] < -100);
      cmpb(stall_err, sp[i] > 100 || sp[i] < -100);
      cmp({28'h0, decay_thr}, (sp[i] > 100 || sp[i] < -100) ? 32'h5 : 32'hF);
      cmpb(decay_always, !(sp[i] > 100 || sp[i] < -100));
      cmp({16'h0, speed_cmd}, {16'h0, sp[i]});
    end
    wr(SMC_A_CTRL, 32'h0);
    @(posedge clock);
    cmpb(stall_det_en, 1'b0);
    stall_raw <= 1'b0;
    // Depth written while running waits until the axis stops
    wr(SMC_A_JERK, 32'h9);
    rd(SMC_A_STATUS, d);
    cmp({25'h0, d[12:6]}, 32'h0);
    speed_req <= 16'sh0;
    repeat (4) @(posedge clock);
    rd(SMC_A_STATUS, d);
    cmp({25'h0, d[12:6]}, 32'h9);
    $display("test stall gate done");
    // Every polarity code on both switches, direction ignored
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr(SMC_A_LIMIT_CFG, 32'h0);
        high[s] <= p[1];
        repeat (4) @(posedge clock);
        wr(SMC_A_LIMIT_CFG, 32'(p) << (2 * s));
        hit[s] <= 1'b1;
        repeat (6) @(posedge clock);
        cmpb(limit_warn, p[0]);
        cmpb(ramp_to_zero, p[0]);
        rchk(SMC_A_ERR_CODE, p[0] ? {24'h0, s ? SMC_ERR_POS : SMC_ERR_NEG} : 32'h0);
        wr(SMC_A_ACK, $urandom);
        repeat (4) @(posedge clock);
        cmpb(limit_warn, 1'b0);
        rchk(SMC_A_ERR_CODE, 32'h0);
        hit[s] <= 1'b0;
        repeat (6) @(posedge clock);
        hit[s] <= 1'b1;
        repeat (6) @(posedge clock);
        cmpb(limit_warn, p[0]);
        hit[s] <= 1'b0;
        repeat (8) @(posedge clock);
        wr(SMC_A_ACK, 32'h0);
      end
    end
    $display("test limit polarity done");
    // Direction monitoring with active-low switches
    for (int s = 0; s < 2; s++) begin
      wr(SMC_A_LIMIT_CFG, 32'h0);
      high <= 2'h0;
      repeat (4) @(posedge clock);
      wr(SMC_A_LIMIT_CFG, 32'h80 | (32'h1 << (2 * s)));
      speed_req <= s ? -16'sd50 : 16'sd50;
      hit[s] <= 1'b1;
      repeat (6) @(posedge clock);
      cmpb(limit_warn, 1'b0);
      rd(SMC_A_STATUS, d);
      cmpb(d[5], 1'b0);
      speed_req <= s ? 16'sd50 : -16'sd50;
      repeat (4) @(posedge clock);
      rd(SMC_A_STATUS, d);
      cmpb(d[5], 1'b1);
      hit[s] <= 1'b0;
      repeat (6) @(posedge clock);
      hit[s] <= 1'b1;
      repeat (6) @(posedge clock);
      cmpb(limit_warn, 1'b1);
      hit[s] <= 1'b0;
      speed_req <= 16'sh0;
      repeat (8) @(posedge clock);
      wr(SMC_A_ACK, 32'h0);
    end
    $display("test direction monitoring done");
    // Second reset in mid-run clears the settings again
    @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rchk(SMC_A_LIMIT_CFG, 32'h0);
    rchk(SMC_A_STALL_MIN, 32'h0);
    $display("test second reset done");
    stop_test;
  end
endmodule // smc_motion_cfg_bench
`default_nettype wire
